// ===== arbf_pkg.sv
// constants shared by the result buffer and formatting block
package arbf_pkg;
    // result buffer geometry
    localparam int ARBF_BUF_MAX_INDEX = 17;
    localparam int ARBF_BUF_DEPTH = ARBF_BUF_MAX_INDEX + 1;
    localparam int ARBF_ADDR_W = 5;
    localparam int ARBF_RAW_W = 13;
    localparam int ARBF_WORD_W = 16;
    localparam int ARBF_CHANNELS = 32;
    localparam int ARBF_FLAG_HALF = 16;
    // output format codes
    localparam logic [1:0] ARBF_FMT_INT = 2'h0;
    localparam logic [1:0] ARBF_FMT_SINT = 2'h1;
    localparam logic [1:0] ARBF_FMT_FRAC = 2'h2;
    localparam logic [1:0] ARBF_FMT_SFRAC = 2'h3;
    // threshold control fields
    localparam int ARBF_TC_MODE_LSB = 0;
    localparam int ARBF_TC_ENABLE_BIT = 2;
    localparam int ARBF_TC_STORE_MATCH_BIT = 3;
    localparam int ARBF_TC_LOWPWR_BIT = 15;
    // compare modes
    localparam logic [1:0] ARBF_CMP_LT = 2'h0;
    localparam logic [1:0] ARBF_CMP_GE = 2'h1;
    localparam logic [1:0] ARBF_CMP_EQ = 2'h2;
    localparam logic [1:0] ARBF_CMP_NE = 2'h3;
    // sample select fields
    localparam int ARBF_SS_CHAN_LSB = 0;
    localparam int ARBF_SS_ALT_MUX_BIT = 5;
    localparam int ARBF_SS_NREF_LSB = 6;
    // reset values
    localparam logic [4:0] ARBF_CHAN_RST = 5'h00;
    localparam logic [31:0] ARBF_FLAGS_RST = 32'h0000_0000;
    localparam logic [15:0] ARBF_WORD_RST = 16'h0000;
endpackage

// ===== arbf_mem_if.sv
// carrier between the control logic and the result buffer memory
`timescale 1ns/1ps
interface arbf_mem_if;
    import arbf_pkg::*;
    logic we;
    logic [ARBF_ADDR_W-1:0] waddr;
    logic [ARBF_RAW_W-1:0] wdata;
    logic [ARBF_ADDR_W-1:0] ra_addr;
    logic [ARBF_RAW_W-1:0] ra_data;
    logic [ARBF_ADDR_W-1:0] rb_addr;
    logic [ARBF_RAW_W-1:0] rb_data;
    modport mem (input we, waddr, wdata, ra_addr, rb_addr, output ra_data, rb_data);
    modport user (output we, waddr, wdata, ra_addr, rb_addr, input ra_data, rb_data);
endinterface

// ===== arbf_mem.sv
// dual read port result buffer memory with registered read data
`timescale 1ns/1ps
module arbf_mem
    import arbf_pkg::*;
#(
    parameter int DEPTH = ARBF_BUF_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // memory ports
    arbf_mem_if.mem m
);
    typedef struct packed {
        logic [DEPTH-1:0][ARBF_RAW_W-1:0] words;
        logic [ARBF_RAW_W-1:0] ra;
        logic [ARBF_RAW_W-1:0] rb;
    } arbf_mem_state_t;

    arbf_mem_state_t q_reg;
    arbf_mem_state_t q_next;

    initial begin
        if (DEPTH < 1 || DEPTH > ARBF_BUF_DEPTH) begin
            $error("arbf_mem: DEPTH out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write and read, out-of-range addresses read zero and ignore writes
    always_comb begin
        q_next = q_reg;
        if (m.we && 32'(m.waddr) < DEPTH) begin
            q_next.words[m.waddr] = m.wdata;
        end
        q_next.ra = (32'(m.ra_addr) < DEPTH) ? q_reg.words[m.ra_addr] : '0;
        q_next.rb = (32'(m.rb_addr) < DEPTH) ? q_reg.words[m.rb_addr] : '0;
    end

    // contents survive reset, only read registers clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            q_reg.words <= q_next.words;
            q_reg.ra <= '0;
            q_reg.rb <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign m.ra_data = q_reg.ra;
    assign m.rb_data = q_reg.rb;
endmodule

// ===== arbf_top.sv
// result buffer, output formatting, threshold match and channel selection
`timescale 1ns/1ps
// Function
// - result buffer of up to eighteen words, indices 0..17, each addressable.
// - while converter on, software writes refused; conversion results stored, only matching ones when detection is active and the store-match bit is set.
// - while converter off, software may write words, used as thresholds.
// - toggling converter on never clears buffer contents.
// - unsigned 12-bit fraction left-justified in 15:4, negatives read zero.
// - signed 12-bit fraction: 13-bit code in 15:3, low bits zero.
// - 10-bit integer right-justified, signed form repeats sign in 15:10.
// - 10-bit fraction in 15:6; signed: sign 15, data 14:5.
// - threshold match flags per channel, low and high flag words.
// - sequential scan converts only channels set in the scan-select words.
// - charge unit enabled for channels selected in charge-unit enable words.
// - sample select picks input multiplexer and negative reference, and the channel while no scan-select bit is set.
// - threshold control configures detection, including power-saving operation.
// - 10-bit differential 11-bit result; unsigned negative zero, signed integer extended.
module arbf_top
    import arbf_pkg::*;
#(
    parameter int DEPTH = ARBF_BUF_DEPTH
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SRST_I,
    // software buffer access
    input wire logic SW_WR_I,
    input wire logic SW_RD_I,
    input wire logic [ARBF_ADDR_W-1:0] SW_ADDR_I,
    input wire logic [ARBF_WORD_W-1:0] SW_WDATA_I,
    output logic [ARBF_WORD_W-1:0] SW_RDATA_O,
    output logic SW_RVALID_O,
    output logic SW_WR_REFUSED_O,
    // configuration
    input wire logic CONVERTER_ON_I,
    input wire logic MODE_12BIT_I,
    input wire logic [1:0] FORMAT_I,
    input wire logic [15:0] THRESHOLD_CONTROL_I,
    input wire logic LOW_POWER_I,
    input wire logic [15:0] SAMPLE_SELECT_I,
    input wire logic [15:0] SCAN_SELECT_LOW_I,
    input wire logic [15:0] SCAN_SELECT_HIGH_I,
    input wire logic [15:0] CHARGE_UNIT_ENABLE_LOW_I,
    input wire logic [15:0] CHARGE_UNIT_ENABLE_HIGH_I,
    // match flags
    input wire logic [31:0] FLAG_CLEAR_I,
    output logic [15:0] MATCH_FLAGS_LOW_O,
    output logic [15:0] MATCH_FLAGS_HIGH_O,
    // converter core
    output logic CONV_START_O,
    output logic [4:0] CHANNEL_O,
    output logic ALT_MUX_O,
    output logic [1:0] NEG_REF_SEL_O,
    output logic CHARGE_UNIT_EN_O,
    input wire logic CONV_DONE_I,
    input wire logic [ARBF_RAW_W-1:0] CONV_RESULT_I
);
    typedef enum logic [1:0] {S_IDLE, S_WAIT, S_CHECK} arbf_state_t;

    typedef struct packed {
        arbf_state_t st;
        logic [4:0] chan;
        logic [ARBF_ADDR_W-1:0] slot;
        logic [ARBF_RAW_W-1:0] result;
        logic start;
        logic alt_mux;
        logic [1:0] nref;
        logic charge_en;
        logic [31:0] flags;
        logic rd_pend;
        logic [ARBF_WORD_W-1:0] rdata;
        logic rvalid;
        logic refused;
    } arbf_ctl_t;

    arbf_ctl_t q_reg;
    arbf_ctl_t q_next;
    arbf_mem_if mif ();

    initial begin
        if (DEPTH < 1 || DEPTH > ARBF_BUF_DEPTH) begin
            $error("arbf_top: DEPTH out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next channel after cur in the scan mask, wrapping
    function automatic logic [4:0] next_scan(input logic [4:0] cur, input logic [31:0] mask);
        logic [4:0] idx;
        logic found;
        next_scan = cur;
        found = 1'b0;
        for (int i = 1; i <= ARBF_CHANNELS; i++) begin
            idx = 5'(32'(cur) + i);
            if (!found && mask[idx]) begin
                next_scan = idx;
                found = 1'b1;
            end
        end
    endfunction

    // raw code to bus word in the selected format
    function automatic logic [15:0] fmt_word(input logic [12:0] r, input logic twelve,
                                             input logic [1:0] fmt);
        logic neg;
        neg = twelve ? r[12] : r[10];
        fmt_word = ARBF_WORD_RST;
        if (twelve) begin
            case (fmt)
                ARBF_FMT_INT: fmt_word = neg ? 16'h0000 : {4'h0, r[11:0]};
                ARBF_FMT_SINT: fmt_word = {{3{r[12]}}, r};
                ARBF_FMT_FRAC: fmt_word = neg ? 16'h0000 : {r[11:0], 4'h0};
                default: fmt_word = {r, 3'h0};
            endcase
        end else begin
            case (fmt)
                ARBF_FMT_INT: fmt_word = neg ? 16'h0000 : {6'h00, r[9:0]};
                ARBF_FMT_SINT: fmt_word = {{5{r[10]}}, r[10:0]};
                ARBF_FMT_FRAC: fmt_word = neg ? 16'h0000 : {r[9:0], 6'h00};
                default: fmt_word = {r[10:0], 5'h00};
            endcase
        end
    endfunction

    // signed compare of a conversion result against a stored threshold
    function automatic logic thr_hit(input logic [12:0] res, input logic [12:0] thr,
                                     input logic [1:0] mode);
        logic signed [12:0] a;
        logic signed [12:0] b;
        a = $signed(res);
        b = $signed(thr);
        case (mode)
            ARBF_CMP_LT: thr_hit = a < b;
            ARBF_CMP_GE: thr_hit = a >= b;
            ARBF_CMP_EQ: thr_hit = a == b;
            default: thr_hit = a != b;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // control, scan sequencing, threshold detection and software read path
    logic [31:0] scan_mask;
    logic [31:0] charge_mask;
    logic thr_active;
    logic hit;
    logic conv_we;
    logic [31:0] set_flags;

    always_comb begin
        scan_mask = {SCAN_SELECT_HIGH_I, SCAN_SELECT_LOW_I};
        charge_mask = {CHARGE_UNIT_ENABLE_HIGH_I, CHARGE_UNIT_ENABLE_LOW_I};
        thr_active = THRESHOLD_CONTROL_I[ARBF_TC_ENABLE_BIT] &&
            (!LOW_POWER_I || THRESHOLD_CONTROL_I[ARBF_TC_LOWPWR_BIT]);
        hit = 1'b0;
        conv_we = 1'b0;
        set_flags = '0;
        q_next = q_reg;
        q_next.start = 1'b0;
        case (q_reg.st)
            S_IDLE: begin
                if (CONVERTER_ON_I) begin
                    if (scan_mask != '0) begin
                        q_next.chan = next_scan(q_reg.chan, scan_mask);
                    end else begin
                        q_next.chan = SAMPLE_SELECT_I[ARBF_SS_CHAN_LSB +: 5];
                    end
                    q_next.alt_mux = SAMPLE_SELECT_I[ARBF_SS_ALT_MUX_BIT];
                    q_next.nref = SAMPLE_SELECT_I[ARBF_SS_NREF_LSB +: 2];
                    q_next.charge_en = charge_mask[q_next.chan];
                    q_next.start = 1'b1;
                    q_next.st = S_WAIT;
                end else begin
                    q_next.slot = '0;
                    q_next.charge_en = 1'b0;
                end
            end
            S_WAIT: begin
                if (!CONVERTER_ON_I) begin
                    q_next.st = S_IDLE;
                end else if (CONV_DONE_I) begin
                    q_next.result = CONV_RESULT_I;
                    q_next.st = S_CHECK;
                end
            end
            S_CHECK: begin
                // stored threshold of this slot is on rb_data now
                hit = thr_active &&
                    thr_hit(q_reg.result, mif.rb_data,
                            THRESHOLD_CONTROL_I[ARBF_TC_MODE_LSB +: 2]);
                conv_we = CONVERTER_ON_I &&
                    (!(thr_active && THRESHOLD_CONTROL_I[ARBF_TC_STORE_MATCH_BIT]) || hit);
                set_flags[q_reg.chan] = hit;
                q_next.slot = (32'(q_reg.slot) >= DEPTH - 1) ? '0 :
                    q_reg.slot + ARBF_ADDR_W'(1);
                q_next.st = S_IDLE;
            end
            default: q_next.st = S_IDLE;
        endcase
        // set wins over a clear in the same cycle
        q_next.flags = (q_reg.flags & ~FLAG_CLEAR_I) | set_flags;
        // two-cycle read: memory register, then formatted output register
        q_next.rd_pend = SW_RD_I;
        q_next.rvalid = q_reg.rd_pend;
        if (q_reg.rd_pend) begin
            q_next.rdata = fmt_word(mif.ra_data, MODE_12BIT_I, FORMAT_I);
        end
        q_next.refused = SW_WR_I && CONVERTER_ON_I;
    end

    // buffer port steering: software writes only while off
    always_comb begin
        mif.we = conv_we || (SW_WR_I && !CONVERTER_ON_I);
        mif.waddr = conv_we ? q_reg.slot : SW_ADDR_I;
        mif.wdata = conv_we ? q_reg.result : SW_WDATA_I[ARBF_RAW_W-1:0];
        mif.ra_addr = SW_ADDR_I;
        mif.rb_addr = q_reg.slot;
    end

    // state register
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            q_reg <= '{st: S_IDLE, chan: ARBF_CHAN_RST, slot: '0, result: '0, start: 1'b0,
                       alt_mux: 1'b0, nref: 2'h0, charge_en: 1'b0, flags: ARBF_FLAGS_RST,
                       rd_pend: 1'b0, rdata: ARBF_WORD_RST, rvalid: 1'b0, refused: 1'b0};
        end else begin
            q_reg <= q_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // buffer memory, untouched by converter on/off
    arbf_mem #(
        .DEPTH(DEPTH)
    ) u_mem (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .m(mif.mem)
    );

    // outputs straight from the state register
    assign SW_RDATA_O = q_reg.rdata;
    assign SW_RVALID_O = q_reg.rvalid;
    assign SW_WR_REFUSED_O = q_reg.refused;
    assign MATCH_FLAGS_LOW_O = q_reg.flags[ARBF_FLAG_HALF-1:0];
    assign MATCH_FLAGS_HIGH_O = q_reg.flags[31:ARBF_FLAG_HALF];
    assign CONV_START_O = q_reg.start;
    assign CHANNEL_O = q_reg.chan;
    assign ALT_MUX_O = q_reg.alt_mux;
    assign NEG_REF_SEL_O = q_reg.nref;
    assign CHARGE_UNIT_EN_O = q_reg.charge_en;
endmodule

// ===== arbf_top_sva.sv
// assertion checker for the result buffer and formatting block
`timescale 1ns/1ps
module arbf_top_chk (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SRST_I,
    // inputs
    input wire logic SW_RD_I,
    input wire logic SW_WR_I,
    input wire logic CONVERTER_ON_I,
    input wire logic [15:0] SAMPLE_SELECT_I,
    input wire logic [15:0] SCAN_SELECT_LOW_I,
    input wire logic [15:0] SCAN_SELECT_HIGH_I,
    input wire logic [15:0] CHARGE_UNIT_ENABLE_LOW_I,
    input wire logic [15:0] CHARGE_UNIT_ENABLE_HIGH_I,
    input wire logic [31:0] FLAG_CLEAR_I,
    input wire logic CONV_DONE_I,
    // outputs
    input wire logic SW_RVALID_O,
    input wire logic SW_WR_REFUSED_O,
    input wire logic [15:0] MATCH_FLAGS_LOW_O,
    input wire logic [15:0] MATCH_FLAGS_HIGH_O,
    input wire logic CONV_START_O,
    input wire logic [4:0] CHANNEL_O,
    input wire logic ALT_MUX_O,
    input wire logic [1:0] NEG_REF_SEL_O,
    input wire logic CHARGE_UNIT_EN_O
);
    // full channel masks
    wire logic [31:0] scan_w = {SCAN_SELECT_HIGH_I, SCAN_SELECT_LOW_I};
    wire logic [31:0] chg_w = {CHARGE_UNIT_ENABLE_HIGH_I, CHARGE_UNIT_ENABLE_LOW_I};
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    // port relations
    property p_rvalid; SW_RD_I |-> ##2 SW_RVALID_O; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer missing");
    property p_refuse; SW_WR_I && CONVERTER_ON_I |=> SW_WR_REFUSED_O; endproperty
    a_refuse: assert property (p_refuse) else $error("write while on not refused");
    property p_off; !CONVERTER_ON_I |=> !CONV_START_O; endproperty
    a_off: assert property (p_off) else $error("start while off");
    property p_scan; CONV_START_O && scan_w != 32'h0 |-> scan_w[CHANNEL_O]; endproperty
    a_scan: assert property (p_scan) else $error("unselected channel scanned");
    property p_direct; CONV_START_O && scan_w == 32'h0 |-> CHANNEL_O == SAMPLE_SELECT_I[4:0]
        && ALT_MUX_O == SAMPLE_SELECT_I[5] && NEG_REF_SEL_O == SAMPLE_SELECT_I[7:6]; endproperty
    a_direct: assert property (p_direct) else $error("sample select ignored");
    property p_charge; CONV_START_O |-> CHARGE_UNIT_EN_O == chg_w[CHANNEL_O]; endproperty
    a_charge: assert property (p_charge) else $error("charge unit enable wrong");
    property p_gap; CONV_START_O |=> !CONV_START_O [*2]; endproperty
    a_gap: assert property (p_gap) else $error("starts too close");
    property p_clear; FLAG_CLEAR_I == 32'hFFFF_FFFF && !CONV_DONE_I && !$past(CONV_DONE_I)
        |=> MATCH_FLAGS_LOW_O == 16'h0000 && MATCH_FLAGS_HIGH_O == 16'h0000; endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared");
    property p_rise; (MATCH_FLAGS_LOW_O & ~$past(MATCH_FLAGS_LOW_O)) != 16'h0000
        |-> $past(CONV_DONE_I, 2); endproperty
    a_rise: assert property (p_rise) else $error("flag set without result");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind arbf_top arbf_top_chk u_chk (.CLK_I(CLK_I), .SRST_I(SRST_I), .SW_RD_I(SW_RD_I),
    .SW_WR_I(SW_WR_I), .CONVERTER_ON_I(CONVERTER_ON_I), .SAMPLE_SELECT_I(SAMPLE_SELECT_I),
    .SCAN_SELECT_LOW_I(SCAN_SELECT_LOW_I), .SCAN_SELECT_HIGH_I(SCAN_SELECT_HIGH_I),
    .CHARGE_UNIT_ENABLE_LOW_I(CHARGE_UNIT_ENABLE_LOW_I), .FLAG_CLEAR_I(FLAG_CLEAR_I),
    .CHARGE_UNIT_ENABLE_HIGH_I(CHARGE_UNIT_ENABLE_HIGH_I), .CONV_DONE_I(CONV_DONE_I),
    .SW_RVALID_O(SW_RVALID_O), .SW_WR_REFUSED_O(SW_WR_REFUSED_O), .CONV_START_O(CONV_START_O),
    .MATCH_FLAGS_LOW_O(MATCH_FLAGS_LOW_O), .MATCH_FLAGS_HIGH_O(MATCH_FLAGS_HIGH_O),
    .CHANNEL_O(CHANNEL_O), .ALT_MUX_O(ALT_MUX_O), .NEG_REF_SEL_O(NEG_REF_SEL_O),
    .CHARGE_UNIT_EN_O(CHARGE_UNIT_EN_O));

// ===== arbf_conv_model.sv
// behavioural converter core answering starts with numbered results
`timescale 1ns/1ps
module arbf_conv_model (
    // clock
    input wire logic clk_i,
    // converter handshake
    input wire logic start_i,
    output logic done_o = 1'b0,
    output logic [12:0] result_o = 13'h0000
);
    int cnt = 0;
    int wait_c = -1;
    // prompt and slow answers alternate, result toggles outside answers
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        result_o <= ~result_o;
        if (start_i) begin
            wait_c <= 1 + 3 * (cnt % 2);
        end else if (wait_c > 0) begin
            wait_c <= wait_c - 1;
        end else if (wait_c == 0) begin
            done_o <= 1'b1;
            result_o <= 13'(32'h40 + cnt);
            cnt <= cnt + 1;
            wait_c <= -1;
        end
    end
endmodule

// ===== test_arbf_top.sv
// self-checking bench for the result buffer and formatting block
`timescale 1ns/1ps
module test_arbf_top;
    import arbf_pkg::*;
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, on = 1'b0, m12 = 1'b0, lp = 1'b0;
    logic [4:0] addr = 5'h00, chan;
    logic [1:0] fmt = 2'h0, nref;
    logic [15:0] wdata = 16'h0000, tc = 16'h0000, ss = 16'h0000, scl = 16'h0000, sch = 16'h0000;
    logic [15:0] cl = 16'h0000, ch = 16'h0000, rdata, fl, fh, sel;
    logic [31:0] fclr = 32'h0000_0000;
    logic [12:0] res;
    logic rvalid, refused, start, alt, cen, done;
    int fail_count = 0, num_checks = 0, cycles = 0, seen;
    // mode, format, raw code, expected word
    logic [31:0] tab [14] = '{32'h8FFF_0FFF, 32'hB000_F000,
        32'hCFFF_FFF0, 32'hD000_0000, 32'hEFFF_7FF8, 32'hF000_8000,
        32'hFFFF_FFF8, 32'h03FF_03FF, 32'h1C00_0000, 32'h3C00_FC00, 32'h3FFF_FFFF,
        32'h43FF_FFC0, 32'h7C00_8000, 32'h6201_4020};
    ////////////////////////////////////////////////////////////////////////////
    // clock and hang ceiling
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    // design and converter model
    arbf_top dut (.CLK_I(clk), .SRST_I(srst), .SW_WR_I(wr), .SW_RD_I(rd), .SW_ADDR_I(addr),
        .SW_WDATA_I(wdata), .SW_RDATA_O(rdata), .SW_RVALID_O(rvalid), .SW_WR_REFUSED_O(refused),
        .CONVERTER_ON_I(on), .MODE_12BIT_I(m12), .FORMAT_I(fmt), .THRESHOLD_CONTROL_I(tc),
        .LOW_POWER_I(lp), .SAMPLE_SELECT_I(ss), .SCAN_SELECT_LOW_I(scl), .SCAN_SELECT_HIGH_I(sch),
        .CHARGE_UNIT_ENABLE_LOW_I(cl), .CHARGE_UNIT_ENABLE_HIGH_I(ch), .FLAG_CLEAR_I(fclr),
        .MATCH_FLAGS_LOW_O(fl), .MATCH_FLAGS_HIGH_O(fh), .CONV_START_O(start), .CHANNEL_O(chan),
        .ALT_MUX_O(alt), .NEG_REF_SEL_O(nref), .CHARGE_UNIT_EN_O(cen), .CONV_DONE_I(done),
        .CONV_RESULT_I(res));
    arbf_conv_model conv (.clk_i(clk), .start_i(start), .done_o(done), .result_o(res));
    ////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask
    // one write, then an idle cycle
    task automatic wr_word(input logic [4:0] a, input logic [15:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1 wr = 1'b0;
        @(posedge clk);
        #1;
    endtask
    // one read, answer checked two cycles on
    task automatic rd_word(input logic [4:0] a, input logic m, input logic [1:0] f,
        input logic [15:0] e);
        rd = 1'b1;
        addr = a;
        m12 = m;
        fmt = f;
        @(posedge clk);
        #1 rd = 1'b0;
        @(posedge clk);
        #1 chk({15'h0000, rvalid}, 16'h0001);
        chk(rdata, e);
    endtask
    // count n results, then switch the converter off
    task automatic run_conv(input int n);
        seen = 0;
        repeat (400) begin
            @(posedge clk);
            if (start === 1'b1) sel = 16'({cen, alt, nref, chan});
            if (done === 1'b1) seen++;
            if (seen == n) break;
        end
        @(posedge clk);
        #1 on = 1'b0;
        chk(seen[15:0], n[15:0]);
        repeat (2) @(posedge clk);
        #1;
    endtask
    // verdict
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        #1 srst = 1'b0;
        for (int i = 0; i < 14; i++) begin
            wr_word(5'(4 + i), {3'b111, tab[i][28:16]});
        end
        for (int i = 0; i < 14; i++) begin
            rd_word(5'(4 + i), tab[i][31], tab[i][30:29], tab[i][15:0]);
        end
        rd_word(5'h12, 1'b0, ARBF_FMT_INT, 16'h0000);
        ss = 16'h00E5;
        cl = 16'h0020;
        ch = 16'h0010;
        on = 1'b1;
        run_conv(2);
        chk(sel, 16'h01E5);
        for (int i = 0; i < 4; i++) wr_word(5'(i), 16'h0000);
        scl = 16'h0008;
        sch = 16'h0010;
        tc = 16'h0007;
        on = 1'b1;
        wr = 1'b1;
        addr = 5'h11;
        @(posedge clk);
        #1 wr = 1'b0;
        chk({15'h0000, refused}, 16'h0001);
        run_conv(4);
        chk(sel, 16'h00E3);
        chk(fl, 16'h0008);
        chk(fh, 16'h0010);
        for (int i = 0; i < 4; i++) rd_word(5'(i), 1'b0, ARBF_FMT_INT, 16'(8'h42 + i));
        rd_word(5'h11, 1'b0, ARBF_FMT_INT, 16'h0201);
        fclr = 32'hFFFF_FFFF;
        @(posedge clk);
        #1 fclr = 32'h0000_0000;
        chk(fl, 16'h0000);
        chk(fh, 16'h0000);
        // power-saving without the keep-detecting bit: no flags
        lp = 1'b1;
        on = 1'b1;
        run_conv(1);
        chk(sel, 16'h01F4);
        chk(fl | fh, 16'h0000);
        print_verdict();
    end
endmodule
